// ==== common/board_pkg.sv ====
// board reset and indicator constants, register map and carrier types
package board_pkg;
    // clock rate and documented delays in their own units
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned IOP_HOLD_US   = 1000;  // 1 ms after processor power good
    localparam int unsigned BOOT_HOLD_US  = 1500;  // 1.5 ms after board reset release
    localparam int unsigned BLINK_HALF_MS = 250;   // sleep blink half period
    // derived cycle counts (exact at 250 MHz)
    localparam logic [19:0] IOP_HOLD_CYC  = 20'(IOP_HOLD_US * CLK_MHZ);
    localparam logic [19:0] BOOT_HOLD_CYC = 20'(BOOT_HOLD_US * CLK_MHZ);
    localparam logic [25:0] BLINK_CYC     = 26'(BLINK_HALF_MS * 1000 * CLK_MHZ);

    // wishbone register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_EVENT  = 8'h08;
    // control and event bit positions
    localparam int unsigned CTRL_SLEEP_EN    = 0;
    localparam int unsigned CTRL_SLEEP_STATE = 1;
    localparam int unsigned CTRL_ID_TOGGLE   = 2;
    localparam int unsigned EVT_SLEEP        = 0;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;

    // board sequencing states
    typedef enum logic [1:0] {
        SEQ_HOLD     = 2'b00,
        SEQ_IOP_WAIT = 2'b01,
        SEQ_RUN      = 2'b10
    } seq_t;

    // rail power-good levels, high means rail in range
    typedef struct packed {
        logic standby_3v3_good;
        logic rail_1v8_good;
        logic rail_1v5_good;
        logic rail_1v35_good;
        logic rail_1v2_good;
    } rails_t;

    // per-drive status from the enclosure controller
    typedef struct packed {
        logic [2:0] present;
        logic [2:0] active;
        logic [2:0] fault;
    } drive_t;

    // every asynchronous board input
    typedef struct packed {
        rails_t     rails;
        logic       host_rail_good_n;
        logic       iop_power_good;
        logic       power_sw_pressed;
        logic       reset_sw_pressed;
        logic       id_sw_pressed;
        logic       alarm_colour_select;
        drive_t     drives;
        logic [1:0] nic_activity;
        logic       critical_alarm;
        logic       major_alarm;
    } inputs_t;

    // front panel indicator drives, high lights the led
    typedef struct packed {
        logic power;
        logic drive_green;
        logic drive_amber;
        logic id;
        logic nic;
        logic crit_yellow;
        logic crit_red;
        logic major_yellow;
        logic major_red;
    } leds_t;

    // status register layout
    typedef struct packed {
        logic [18:0] zero;
        seq_t        seq;
        logic        id_led;
        logic        power_on;
        logic        iop_reset_n;
        logic        board_reset_n;
        logic        iop_power_good;
        logic        host_rail_good_n;
        rails_t      rails;
    } status_t;
endpackage

// ==== hw/board_reset_leds.sv ====
// board reset sequencing and front panel indicators with wishbone registers
//
// Added by the designer: the Wishbone slave port and the register offsets.

module board_reset_leds #(
    parameter logic [19:0] IOP_HOLD_CYCLES  = board_pkg::IOP_HOLD_CYC,
    parameter logic [19:0] BOOT_HOLD_CYCLES = board_pkg::BOOT_HOLD_CYC,
    parameter logic [25:0] BLINK_CYCLES     = board_pkg::BLINK_CYC
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire board_pkg::inputs_t board_in,
    output logic                    board_reset_n,
    output logic                    iop_reset_n,
    output board_pkg::leds_t        leds,
    output logic                    system_reset,
    output logic                    sleep_button,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o
);
    // whole state of the block
    typedef struct packed {
        board_pkg::inputs_t sync1;        // first synchroniser stage
        board_pkg::inputs_t sync2;        // second stage, the only one used
        logic [2:0]         sw_prev;      // power, reset, id switch last level
        board_pkg::seq_t    seq;          // reset sequencing state
        logic               board_rst_n;  // board reset output
        logic               iop_rst_n;    // processor reset output
        logic               power_on;     // system power state
        logic               sleep_en;     // os enabled the sleep button
        logic               sleep_state;  // system in acpi sleep
        logic               sleep_evt;    // sticky sleep button event
        logic               id_on;        // id led state
        logic               sys_rst;      // system reset pulse
        logic               sleep_btn;    // sleep button pulse
        logic [25:0]        blink_cnt;    // blink half period counter
        logic               blink;        // blink phase
        board_pkg::leds_t   led;          // registered led drives
        logic               ack;          // bus acknowledge
        logic [31:0]        dat;          // bus read data
    } state_t;

    state_t state;       // registered copy
    state_t next_state;  // combinational copy

    logic              iop_done;    // processor power good hold expired
    logic              boot_done;   // board release hold expired
    logic              all_good;    // every rail and host good
    logic              pwr_press;   // power switch press
    logic              rst_press;   // reset switch press
    logic              id_press;    // id switch press
    logic              bus_req;     // new wishbone request
    logic              bus_wr;      // write with low byte enabled
    logic              id_ev;       // any id toggle request
    logic              any_fault;   // a present drive reports fault
    logic              any_active;  // a present drive is active
    logic              iop_run;     // processor hold timer running
    board_pkg::status_t status;     // status register image

    // rising edge of a synchronised switch level
    function automatic logic rise(input logic cur, input logic prev);
        return cur && !prev;
    endfunction

    assign all_good = (&state.sync2.rails) && state.sync2.host_rail_good_n;

    assign pwr_press = rise(state.sync2.power_sw_pressed, state.sw_prev[2]);
    assign rst_press = rise(state.sync2.reset_sw_pressed, state.sw_prev[1]);
    assign id_press  = rise(state.sync2.id_sw_pressed, state.sw_prev[0]);

    // a request is taken once; ack drops the cycle after it rises
    assign bus_req = wb_cyc_i && wb_stb_i && !state.ack;
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

    assign id_ev = id_press || (bus_wr && (wb_adr_i == board_pkg::REG_CTRL)
                   && wb_dat_i[board_pkg::CTRL_ID_TOGGLE]);

    assign any_fault  = |(state.sync2.drives.fault & state.sync2.drives.present);
    assign any_active = |(state.sync2.drives.active & state.sync2.drives.present);

    // status register image built from live state
    always_comb begin
        status                  = '0;
        status.seq              = state.seq;
        status.id_led           = state.id_on;
        status.power_on         = state.power_on;
        status.iop_reset_n      = state.iop_rst_n;
        status.board_reset_n    = state.board_rst_n;
        status.iop_power_good   = state.sync2.iop_power_good;
        status.host_rail_good_n = state.sync2.host_rail_good_n;
        status.rails            = state.sync2.rails;
    end

    assign iop_run = (state.seq != board_pkg::SEQ_HOLD) && state.sync2.iop_power_good;
    hold_timer #(
        .CYCLES (IOP_HOLD_CYCLES)
    ) iop_timer (
        .clk   (clk),
        .reset (reset),
        .run   (iop_run),
        .done  (iop_done)
    );

    hold_timer #(
        .CYCLES (BOOT_HOLD_CYCLES)
    ) boot_timer (
        .clk   (clk),
        .reset (reset),
        .run   (state.seq != board_pkg::SEQ_HOLD),
        .done  (boot_done)
    );

    // next state of the whole block
    always_comb begin
        next_state = state;
        next_state.sync1   = board_in;
        next_state.sync2   = state.sync1;
        next_state.sw_prev = {state.sync2.power_sw_pressed, state.sync2.reset_sw_pressed,
                              state.sync2.id_sw_pressed};
        next_state.sys_rst   = 1'b0;
        next_state.sleep_btn = 1'b0;

        case (state.seq)
            board_pkg::SEQ_HOLD: begin
                if (all_good) begin
                    next_state.seq = board_pkg::SEQ_IOP_WAIT;
                end
            end
            board_pkg::SEQ_IOP_WAIT: begin
                // both holds must expire, whichever is later
                if (!all_good) begin
                    next_state.seq = board_pkg::SEQ_HOLD;
                end else if (iop_done && boot_done) begin
                    next_state.seq = board_pkg::SEQ_RUN;
                end
            end
            board_pkg::SEQ_RUN: begin
                // a lost processor supply restarts its hold
                if (!all_good) begin
                    next_state.seq = board_pkg::SEQ_HOLD;
                end else if (!state.sync2.iop_power_good) begin
                    next_state.seq = board_pkg::SEQ_IOP_WAIT;
                end
            end
            default: begin
                next_state.seq = board_pkg::SEQ_HOLD;
            end
        endcase
        // outputs follow the next sequencing state
        next_state.board_rst_n = (next_state.seq != board_pkg::SEQ_HOLD);
        next_state.iop_rst_n   = (next_state.seq == board_pkg::SEQ_RUN);

        if (pwr_press) begin
            if (state.sleep_en) begin
                next_state.sleep_btn = 1'b1;
                next_state.sleep_evt = 1'b1;
            end else begin
                next_state.power_on = !state.power_on;
            end
        end
        if (rst_press && state.power_on) begin
            next_state.sys_rst = 1'b1;
        end
        if (id_ev) begin
            next_state.id_on = !state.id_on;
        end

        if (state.blink_cnt == BLINK_CYCLES - 26'h0000001) begin
            next_state.blink_cnt = 26'h0000000;
            next_state.blink     = !state.blink;
        end else begin
            next_state.blink_cnt = state.blink_cnt + 26'h0000001;
        end

        // wishbone slave: one wait state, unmapped reads zero
        next_state.ack = bus_req;
        if (bus_req) begin
            case (wb_adr_i)
                board_pkg::REG_CTRL: begin
                    next_state.dat = {30'h00000000, state.sleep_state, state.sleep_en};
                end
                board_pkg::REG_STATUS: begin
                    next_state.dat = status;
                end
                board_pkg::REG_EVENT: begin
                    next_state.dat = {31'h00000000, state.sleep_evt};
                end
                default: begin
                    next_state.dat = 32'h00000000;
                end
            endcase
        end
        if (bus_wr && (wb_adr_i == board_pkg::REG_CTRL)) begin
            next_state.sleep_en    = wb_dat_i[board_pkg::CTRL_SLEEP_EN];
            next_state.sleep_state = wb_dat_i[board_pkg::CTRL_SLEEP_STATE];
        end
        // write one clears; a new press in the same cycle wins
        if (bus_wr && (wb_adr_i == board_pkg::REG_EVENT) && wb_dat_i[board_pkg::EVT_SLEEP]
            && !(pwr_press && state.sleep_en)) begin
            next_state.sleep_evt = 1'b0;
        end

        next_state.led.power = state.power_on && (!state.sleep_state || state.blink);
        next_state.led.drive_amber = any_fault;
        next_state.led.drive_green = any_active && !any_fault;
        next_state.led.id          = next_state.id_on;
        next_state.led.nic = |state.sync2.nic_activity;
        next_state.led.crit_red     = state.sync2.critical_alarm && state.sync2.alarm_colour_select;
        next_state.led.crit_yellow  = state.sync2.critical_alarm && !state.sync2.alarm_colour_select;
        next_state.led.major_red    = state.sync2.major_alarm && state.sync2.alarm_colour_select;
        next_state.led.major_yellow = state.sync2.major_alarm && !state.sync2.alarm_colour_select;
    end

    // register the state; everything clears to off and held in reset
    always_ff @(posedge clk) begin
        if (reset) begin
            state             <= '0;
            state.seq         <= board_pkg::SEQ_HOLD;
            state.sleep_en    <= board_pkg::CTRL_RST[0];
            state.sleep_state <= board_pkg::CTRL_RST[1];
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flip-flops
    assign board_reset_n = state.board_rst_n;
    assign iop_reset_n   = state.iop_rst_n;
    assign leds          = state.led;
    assign system_reset  = state.sys_rst;
    assign sleep_button  = state.sleep_btn;
    assign wb_dat_o      = state.dat;
    assign wb_ack_o      = state.ack;

    // helper ages for checking hold times
    logic [19:0] pg_age;    // cycles of processor power good while released
    logic [19:0] rel_age;   // cycles since board release
    always_ff @(posedge clk) begin
        if (reset || !iop_run) begin
            pg_age <= 20'h00000;
        end else if (pg_age != 20'hfffff) begin
            pg_age <= pg_age + 20'h00001;
        end
    end
    always_ff @(posedge clk) begin
        if (reset || !state.board_rst_n) begin
            rel_age <= 20'h00000;
        end else if (rel_age != 20'hfffff) begin
            rel_age <= rel_age + 20'h00001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // id request and awake state sequences
    sequence s_id_req;
        id_ev;
    endsequence
    sequence s_awake;
        state.power_on && !state.sleep_state;
    endsequence

    AST_RAIL_POLARITY: assert property (
        !(&state.sync2.rails) |=> !board_reset_n)
        else $error("board released with a rail low");
    AST_BOARD_HOLD: assert property (
        !all_good |=> !board_reset_n && !iop_reset_n)
        else $error("board reset released before all good");
    AST_HOST_RESET: assert property (
        !state.sync2.host_rail_good_n |=> !board_reset_n && !iop_reset_n)
        else $error("host rail low did not reset board");
    AST_IOP_HOLD: assert property (
        $rose(iop_reset_n) |-> pg_age >= IOP_HOLD_CYCLES)
        else $error("processor reset released before power good hold");
    AST_POWER_LED: assert property (
        s_awake |=> leds.power)
        else $error("power led dark while on and awake");
    AST_DRIVE_LED: assert property (
        any_fault |=> leds.drive_amber && !leds.drive_green)
        else $error("drive fault not shown amber");
    AST_ID_TOGGLE: assert property (
        s_id_req |=> leds.id != $past(leds.id))
        else $error("id led did not toggle");
    AST_ALARM_YELLOW: assert property (
        state.sync2.critical_alarm && !state.sync2.alarm_colour_select
        |=> leds.crit_yellow && !leds.crit_red)
        else $error("critical alarm not yellow by default");
    AST_RESET_SW: assert property (
        rst_press && !state.power_on |=> !system_reset)
        else $error("reset switch acted while powered off");
    AST_POWER_SW: assert property (
        pwr_press && state.sleep_en |=> sleep_button && $stable(state.power_on))
        else $error("sleep enabled press changed power");
    AST_NIC_LED: assert property (
        (|state.sync2.nic_activity) |=> leds.nic)
        else $error("network led dark with activity");
    AST_ALARM_RED: assert property (
        state.sync2.major_alarm && state.sync2.alarm_colour_select |=> leds.major_red && !leds.major_yellow)
        else $error("major alarm ignored colour select");
    AST_BOOT_HOLD: assert property (
        $rose(iop_reset_n) |-> rel_age >= BOOT_HOLD_CYCLES)
        else $error("processor reset released before board hold");
endmodule // board_reset_leds

// ==== hw/hold_timer.sv ====
// saturating hold-off timer: done after CYCLES cycles of run
module hold_timer #(
    parameter logic [19:0] CYCLES = 20'h00001
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic run,
    output logic      done
);
    // whole state of the timer
    typedef struct packed {
        logic [19:0] count;
    } timer_state_t;

    timer_state_t state;       // registered copy
    timer_state_t next_state;  // combinational copy

    // count while run stays high, restart whenever it drops
    always_comb begin
        next_state = state;
        if (!run) begin
            next_state.count = 20'h00000;
        end else if (state.count != CYCLES) begin
            next_state.count = state.count + 20'h00001;
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // saturated count means the full delay has passed
    assign done = run && (state.count == CYCLES);
endmodule // hold_timer

// ==== test/board_partner.sv ====
// model of the on-board regulators and the host board feeding the reset logic
module board_partner (
    input  wire logic          clk,
    input  wire logic          rails_on,
    input  wire logic          host_on,
    input  wire logic          iop_on,
    input  wire logic          drop_1v2,
    output board_pkg::rails_t  rails,
    output logic               host_rail_good_n,
    output logic               iop_power_good
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] step;  // regulator ramp position, rails come good one by one

    // rails ramp in order so the last good decides the release moment
    always_ff @(posedge clk) begin
        if (!rails_on) begin
            step <= 3'h0;
        end else if (step != 3'h4) begin
            step <= step + 3'h1;
        end
        rails.standby_3v3_good <= rails_on;
        rails.rail_1v8_good    <= rails_on && step >= 3'h1;
        rails.rail_1v5_good    <= rails_on && step >= 3'h2;
        rails.rail_1v35_good   <= rails_on && step >= 3'h3;
        rails.rail_1v2_good    <= rails_on && step >= 3'h4 && !drop_1v2;
        // host rail good, low acts as fundamental reset
        host_rail_good_n       <= host_on;
        // processor power good needs its supplies first
        iop_power_good         <= iop_on && (&rails);
    end
endmodule // board_partner

// ==== test/board_reset_and_status_leds_bench.sv ====
// self-checking bench for board reset sequencing and front panel indicators
module board_reset_and_status_leds_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] IOP_HOLD  = 20'h00014;  // shortened processor hold
    localparam logic [19:0] BOOT_HOLD = 20'h0001e;  // shortened boot hold
    logic               clk = 1'b0;
    logic               reset = 1'b1;
    board_pkg::inputs_t drv = '0;      // bench-driven board inputs
    board_pkg::inputs_t board_in;      // what the design sees
    board_pkg::rails_t  p_rails;
    logic               p_host_n, p_pg, board_reset_n, iop_reset_n, system_reset, sleep_button;
    logic               rails_on = 1'b0, host_on = 1'b0, iop_on = 1'b0, drop_1v2 = 1'b0;
    logic [2:0]         sw = 3'h0;     // id, reset, power switches
    board_pkg::leds_t   leds;
    logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]         wb_adr_i = 8'h00;
    logic [3:0]         wb_sel_i = 4'hf;
    logic [31:0]        wb_dat_i = 32'h0, wb_dat_o;
    int                 mismatches = 0, num_checks = 0, n_rst = 0, n_slp = 0, cycles = 0;

    always #2 clk = ~clk;

    // partner lines and switches override the bench struct
    always_comb begin
        board_in = drv;
        board_in.rails = p_rails;
        board_in.host_rail_good_n = p_host_n;
        board_in.iop_power_good = p_pg;
        {board_in.id_sw_pressed, board_in.reset_sw_pressed, board_in.power_sw_pressed} = sw;
    end

    board_partner u_partner (.clk(clk), .rails_on(rails_on), .host_on(host_on), .iop_on(iop_on),
        .drop_1v2(drop_1v2), .rails(p_rails), .host_rail_good_n(p_host_n), .iop_power_good(p_pg));

    board_reset_leds #(.IOP_HOLD_CYCLES(IOP_HOLD), .BOOT_HOLD_CYCLES(BOOT_HOLD),
        .BLINK_CYCLES(26'h0000008)) u_dut (
        .clk(clk), .reset(reset), .board_in(board_in), .board_reset_n(board_reset_n),
        .iop_reset_n(iop_reset_n), .leds(leds), .system_reset(system_reset),
        .sleep_button(sleep_button), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o));

    // pulse counters and hang guard, a few thousand cycles is ample
    always @(posedge clk) begin
        cycles++;
        if (system_reset === 1'b1) n_rst++;
        if (sleep_button === 1'b1) n_slp++;
        if (cycles == 4000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        // no fixed latency assumed; only the hang guard ends this wait
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_board(output int n);
        n = 0;
        while (board_reset_n !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    endtask

    task automatic wait_iop(output int n);
        n = 0;
        while (iop_reset_n !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    endtask

    // one press held several cycles must act once
    task automatic press(input int k);
        sw[k] <= 1'b1;
        tick(4);
        sw <= 3'h0;
        tick(6);
    endtask

    task automatic test_power_up();
        int n;
        logic [31:0] rd;
        check({board_reset_n, iop_reset_n, leds}, 32'h0, "reset values");
        rails_on <= 1'b1;
        iop_on <= 1'b1;
        tick(30);
        check(board_reset_n, 32'h0, "released without host good");
        wb(1'b0, board_pkg::REG_STATUS, 32'h0, rd);
        check(rd, 32'h0000005f, "status before host good");
        host_on <= 1'b1;
        wait_board(n);
        check(n <= 6, 32'h1, "board release latency");
        wait_iop(n);
        check(n >= BOOT_HOLD && n <= BOOT_HOLD + 6, 32'h1, "boot hold length");
    endtask

    task automatic test_rail_drop();
        int n;
        drop_1v2 <= 1'b1;
        iop_on <= 1'b0;
        tick(6);
        check({board_reset_n, iop_reset_n}, 32'h0, "resets after rail drop");
        drop_1v2 <= 1'b0;
        wait_board(n);
        tick(40);
        check(iop_reset_n, 32'h0, "released without power good");
        iop_on <= 1'b1;
        wait_iop(n);
        check(n >= IOP_HOLD && n <= IOP_HOLD + 8, 32'h1, "processor hold length");
    endtask

    task automatic test_leds();
        logic [10:0] tbl [5] = '{11'h0fc, 11'h742, 11'h511, 11'h729, 11'h200};
        logic [2:0] j;
        for (int i = 0; i < 5; i++) begin
            drv.drives <= tbl[i][10:2];
            tick(6);
            check({leds.drive_green, leds.drive_amber}, tbl[i][1:0], "drive led");
        end
        for (int i = 0; i < 8; i++) begin
            j = 3'(i);
            {drv.alarm_colour_select, drv.critical_alarm, drv.major_alarm} <= j;
            drv.nic_activity <= j[1:0];
            tick(6);
            check(leds.nic, |j[1:0], "network led");
            check({leds.crit_yellow, leds.crit_red, leds.major_yellow, leds.major_red},
                {j[1] & !j[2], j[1] & j[2], j[0] & !j[2], j[0] & j[2]}, "alarm colour");
        end
    endtask

    task automatic test_switches();
        int ones;
        logic [31:0] rd;
        ones = 0;
        press(1);
        check(n_rst, 32'h0, "reset switch while off");
        press(0);
        check(leds.power, 32'h1, "power on steady");
        press(1);
        check(n_rst, 32'h1, "reset switch while on");
        press(2);
        check(leds.id, 32'h1, "id switch toggle");
        wb(1'b1, board_pkg::REG_CTRL, 32'h4, rd);
        tick(4);
        check(leds.id, 32'h0, "remote id toggle");
        wb(1'b1, board_pkg::REG_CTRL, 32'h2, rd);
        repeat (40) begin @(posedge clk); ones += int'(leds.power === 1'b1); end
        check(ones >= 12 && ones <= 28, 32'h1, "sleep blink");
        wb(1'b1, board_pkg::REG_CTRL, 32'h1, rd);
        press(0);
        check({n_slp[1:0], leds.power}, 32'h3, "sleep button event");
        wb(1'b0, board_pkg::REG_EVENT, 32'h0, rd);
        check(rd, 32'h1, "sleep event flag");
        wb(1'b1, board_pkg::REG_EVENT, 32'h1, rd);
        wb(1'b0, board_pkg::REG_EVENT, 32'h0, rd);
        check(rd, 32'h0, "sleep event cleared");
        wb(1'b0, board_pkg::REG_CTRL, 32'h0, rd);
        check(rd, 32'h1, "control readback");
        wb(1'b0, 8'h40, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        wb(1'b1, board_pkg::REG_CTRL, 32'h0, rd);
        press(0);
        check(leds.power, 32'h0, "power toggled off");
        press(1);
        check(n_rst, 32'h1, "reset switch after off");
    endtask

    // processor supply loss while running, then host rail loss
    task automatic test_host_drop();
        logic [31:0] rd;
        iop_on <= 1'b0;
        tick(6);
        check({board_reset_n, iop_reset_n}, 32'h2, "processor supply lost");
        wb(1'b0, board_pkg::REG_STATUS, 32'h0, rd);
        check(rd, 32'h000008bf, "status waiting for processor");
        host_on <= 1'b0;
        tick(6);
        check({board_reset_n, iop_reset_n}, 32'h0, "host rail low");
    endtask

    // main sequence
    initial begin
        tick(20);
        reset <= 1'b0;
        @(posedge clk);
        test_power_up();
        test_rail_drop();
        test_leds();
        test_switches();
        test_host_drop();
        finish_test();
    end
endmodule // board_reset_and_status_leds_bench
